// file: logic/btb_device.sv
// Purpose: Debug monitor with two address comparators, trace store and forced reset control.
// Assumes: CPU bus signals are synchronous to i_clk; trigger mode comes from outside.
// Notes: Rules follow.
// Notes on behaviour
// - Forced reset ignores application program writes.
// - Forced reset register always reads zero.
// - Serial write of bit0 forces reset.
// - Nine monitor bytes readable by application code.
// - Comparator bytes reset zero, write when unarmed.
// - High port read-only, zero in event modes.
// - Low read advances; high read does not.
// - Reader fetches high byte before low.
// - No advance on low reads while armed.
// - Unarmed low read stores last opcode address.
// - Unarmed reads form eight deep delay.
// - Control register accessible at any time.
// - Monitor enable refused while secure.
// - Arm bit sets flag, clears on end.
// - Bit5 selects tag or force break.
// - Bit4 enables breaks from trigger events.
// - Qualify select does not move break timing.
// - Bits 3:2 qualify comparator A direction.
// - Bits 1:0 qualify comparator B direction.
// - Run ends on full or trigger.
// - Event modes always run begin traces.
`timescale 1ns/10ps
module btb_device (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register link
    btb_if.device bus,
    // CPU bus
    input wire logic i_bus_valid,
    input wire logic i_bus_read,
    input wire logic [15:0] i_bus_addr,
    input wire logic [7:0] i_bus_data,
    input wire logic i_opcode_fetch,
    input wire logic i_opcode_exec,
    input wire logic i_secure,
    // Trigger setup
    input wire logic [3:0] i_trig_mode,
    input wire logic i_begin_trace,
    input wire logic i_trigger_qualify_select,
    // Results
    output logic o_force_reset,
    output logic o_break_req,
    output logic o_break_tag,
    output logic o_armed,
    output logic [3:0] o_fifo_count
);
    logic [7:0] ctl_q;
    logic [7:0] cah_q;
    logic [7:0] cal_q;
    logic [7:0] cbh_q;
    logic [7:0] cbl_q;
    logic [15:0] fifo_q [btb_pkg::FIFO_DEPTH];
    logic [3:0] cnt_q;
    logic a_flag_q;
    logic b_flag_q;
    logic a_seen_q;
    logic begun_q;
    logic [15:0] last_fetch_q;
    logic [7:0] rdata_q;
    logic ack_q;
    logic force_q;
    logic brk_q;
    logic acc;
    logic wr_acc;
    logic rd_low;
    logic armed;
    logic event_only;
    logic begin_trace;
    logic dir_a_ok;
    logic dir_b_ok;
    logic qual_ok;
    logic match_a;
    logic match_b;
    logic data_b;
    logic trig;
    logic store;
    logic run_end;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] store_word;
    logic [7:0] ctl_wr;
    logic [7:0] status;

    assign acc = bus.req && !ack_q;
    assign wr_acc = acc && bus.wr;
    assign rd_low = acc && !bus.wr && bus.addr == btb_pkg::OFS_FIFO_LOW;
    assign armed = ctl_q[btb_pkg::CTL_ARM];
    assign cmp_a = {cah_q, cal_q};
    assign cmp_b = {cbh_q, cbl_q};
    assign event_only = i_trig_mode == btb_pkg::TRG_EVENT_B || i_trig_mode == btb_pkg::TRG_A_THEN_EVENT_B;
    assign begin_trace = event_only || i_begin_trace;
    assign dir_a_ok = !ctl_q[btb_pkg::CTL_A_DIR_QUALIFY] || (i_bus_read == ctl_q[btb_pkg::CTL_A_DIR_VALUE]);
    assign dir_b_ok = !ctl_q[btb_pkg::CTL_B_DIR_QUALIFY] || (i_bus_read == ctl_q[btb_pkg::CTL_B_DIR_VALUE]);
    assign qual_ok = !i_trigger_qualify_select || i_opcode_exec;
    assign match_a = armed && i_bus_valid && qual_ok && dir_a_ok && i_bus_addr == cmp_a;
    assign match_b = armed && i_bus_valid && qual_ok && dir_b_ok && i_bus_addr == cmp_b;
    assign data_b = match_a && i_bus_data == cbl_q;

    always_comb
    begin
        unique case (i_trig_mode)
            btb_pkg::TRG_A_ONLY: trig = match_a;
            btb_pkg::TRG_A_OR_B: trig = match_a || match_b;
            btb_pkg::TRG_A_THEN_B: trig = match_b && a_seen_q;
            btb_pkg::TRG_EVENT_B: trig = match_b;
            btb_pkg::TRG_A_THEN_EVENT_B: trig = match_b && a_seen_q;
            btb_pkg::TRG_A_AND_B_DATA: trig = data_b;
            btb_pkg::TRG_A_AND_NOT_B_DATA: trig = match_a && i_bus_data != cbl_q;
            btb_pkg::TRG_INSIDE: trig = armed && i_bus_valid && qual_ok && i_bus_addr >= cmp_a && i_bus_addr <= cmp_b;
            btb_pkg::TRG_OUTSIDE: trig = armed && i_bus_valid && qual_ok && (i_bus_addr < cmp_a || i_bus_addr > cmp_b);
            default: trig = 1'b0;
        endcase
    end

    // Event modes store the data byte at each event; others store fetch addresses.
    always_comb
    begin
        store = 1'b0;
        store_word = i_bus_addr;
        if (armed && event_only)
        begin
            store = trig;
            store_word = {8'h00, i_bus_data};
        end
        else if (armed && begin_trace)
        begin
            store = i_opcode_fetch && (begun_q || trig);
        end
        else if (armed)
        begin
            store = i_opcode_fetch;
        end
    end

    // A begin trace ends when the store fills, an end trace at its trigger.
    assign run_end = armed && (begin_trace ? (store && cnt_q == btb_pkg::FIFO_FULL_COUNT - 4'h1) : trig);

    always_comb
    begin
        ctl_wr = bus.wdata;
        if (i_secure && !ctl_q[btb_pkg::CTL_MONITOR_ENABLE])
        begin
            ctl_wr[btb_pkg::CTL_MONITOR_ENABLE] = 1'b0;
        end
        if (!ctl_wr[btb_pkg::CTL_MONITOR_ENABLE])
        begin
            ctl_wr[btb_pkg::CTL_ARM] = 1'b0;
        end
    end

    // Software writes win over a run ending in the same cycle.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctl_q <= btb_pkg::RESET_BYTE;
        end
        else if (wr_acc && bus.addr == btb_pkg::OFS_CONTROL)
        begin
            ctl_q <= ctl_wr;
        end
        else if (run_end)
        begin
            ctl_q[btb_pkg::CTL_ARM] <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cah_q <= btb_pkg::RESET_BYTE;
            cal_q <= btb_pkg::RESET_BYTE;
            cbh_q <= btb_pkg::RESET_BYTE;
            cbl_q <= btb_pkg::RESET_BYTE;
        end
        else if (wr_acc && !armed)
        begin
            if (bus.addr == btb_pkg::OFS_CMP_A_HIGH)
                cah_q <= bus.wdata;
            if (bus.addr == btb_pkg::OFS_CMP_A_LOW)
                cal_q <= bus.wdata;
            if (bus.addr == btb_pkg::OFS_CMP_B_HIGH)
                cbh_q <= bus.wdata;
            if (bus.addr == btb_pkg::OFS_CMP_B_LOW)
                cbl_q <= bus.wdata;
        end
    end

    // Run bookkeeping is cleared when a write arms the monitor.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_q <= 4'h0;
            a_flag_q <= 1'b0;
            b_flag_q <= 1'b0;
            a_seen_q <= 1'b0;
            begun_q <= 1'b0;
        end
        else if (wr_acc && bus.addr == btb_pkg::OFS_CONTROL && ctl_wr[btb_pkg::CTL_ARM] && !armed)
        begin
            cnt_q <= 4'h0;
            a_flag_q <= 1'b0;
            b_flag_q <= 1'b0;
            a_seen_q <= 1'b0;
            begun_q <= 1'b0;
        end
        else if (armed)
        begin
            if (store && cnt_q != btb_pkg::FIFO_FULL_COUNT)
                cnt_q <= cnt_q + 4'h1;
            a_flag_q <= a_flag_q || match_a;
            b_flag_q <= b_flag_q || match_b;
            a_seen_q <= a_seen_q || match_a;
            begun_q <= begun_q || trig;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            last_fetch_q <= btb_pkg::RESET_WORD;
        else if (i_bus_valid && i_opcode_fetch)
            last_fetch_q <= i_bus_addr;
    end

    // The store is a shift line: words enter at the top and are read at the bottom.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int i = 0; i < btb_pkg::FIFO_DEPTH; i++)
                fifo_q[i] <= btb_pkg::RESET_WORD;
        end
        else if (store || (rd_low && !armed))
        begin
            for (int i = 0; i < btb_pkg::FIFO_DEPTH - 1; i++)
                fifo_q[i] <= fifo_q[i + 1];
            fifo_q[btb_pkg::FIFO_DEPTH - 1] <= store ? store_word : last_fetch_q;
        end
    end

    always_comb
    begin
        status = btb_pkg::RESET_BYTE;
        status[btb_pkg::STS_A_FLAG] = a_flag_q;
        status[btb_pkg::STS_B_FLAG] = b_flag_q;
        status[btb_pkg::STS_ARMED] = armed && ctl_q[btb_pkg::CTL_MONITOR_ENABLE];
        status[3:0] = cnt_q;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rdata_q <= btb_pkg::RESET_BYTE;
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= acc;
            if (acc && !bus.wr)
            begin
                unique case (bus.addr)
                    btb_pkg::OFS_CMP_A_HIGH: rdata_q <= cah_q;
                    btb_pkg::OFS_CMP_A_LOW: rdata_q <= cal_q;
                    btb_pkg::OFS_CMP_B_HIGH: rdata_q <= cbh_q;
                    btb_pkg::OFS_CMP_B_LOW: rdata_q <= cbl_q;
                    btb_pkg::OFS_FIFO_HIGH: rdata_q <= event_only ? btb_pkg::RESET_BYTE : fifo_q[0][15:8];
                    btb_pkg::OFS_FIFO_LOW: rdata_q <= fifo_q[0][7:0];
                    btb_pkg::OFS_CONTROL: rdata_q <= ctl_q;
                    btb_pkg::OFS_STATUS: rdata_q <= status;
                    default: rdata_q <= btb_pkg::RESET_BYTE;
                endcase
            end
        end
    end

    // Forced reset pulses only for a serial debug write of a one.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            force_q <= 1'b0;
        else
            force_q <= wr_acc && bus.serial && bus.addr == btb_pkg::OFS_FORCED_RESET
                && bus.wdata[btb_pkg::FORCE_RESET_BIT];
    end

    // Break timing depends only on the run end, not on the qualify select.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            brk_q <= 1'b0;
        else
            brk_q <= run_end && ctl_q[btb_pkg::CTL_BREAK_ENABLE];
    end

    assign bus.ack = ack_q;
    assign bus.rdata = rdata_q;
    assign o_force_reset = force_q;
    assign o_break_req = brk_q;
    assign o_break_tag = ctl_q[btb_pkg::CTL_TAG];
    assign o_armed = status[btb_pkg::STS_ARMED];
    assign o_fifo_count = cnt_q;
endmodule

// file: logic/btb_pkg.sv
// Purpose: Shared constants for the bus trace and breakpoint unit and its debug host.
// Assumes: Byte-wide register window reached through btb_if.
// Notes: Host register words are 32-bit aligned on AXI4-Lite.
package btb_pkg;
    // Byte offsets inside the monitor register window.
    localparam logic [3:0] OFS_FORCED_RESET = 4'h0;
    localparam logic [3:0] OFS_CMP_A_HIGH = 4'h1;
    localparam logic [3:0] OFS_CMP_A_LOW = 4'h2;
    localparam logic [3:0] OFS_CMP_B_HIGH = 4'h3;
    localparam logic [3:0] OFS_CMP_B_LOW = 4'h4;
    localparam logic [3:0] OFS_FIFO_HIGH = 4'h5;
    localparam logic [3:0] OFS_FIFO_LOW = 4'h6;
    localparam logic [3:0] OFS_CONTROL = 4'h7;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    // Bit positions in monitor_control.
    localparam int CTL_MONITOR_ENABLE = 7;
    localparam int CTL_ARM = 6;
    localparam int CTL_TAG = 5;
    localparam int CTL_BREAK_ENABLE = 4;
    localparam int CTL_A_DIR_VALUE = 3;
    localparam int CTL_A_DIR_QUALIFY = 2;
    localparam int CTL_B_DIR_VALUE = 1;
    localparam int CTL_B_DIR_QUALIFY = 0;
    // Bit positions in the status byte and the forced reset byte.
    localparam int STS_A_FLAG = 7;
    localparam int STS_B_FLAG = 6;
    localparam int STS_ARMED = 5;
    localparam int FORCE_RESET_BIT = 0;
    // Reset values.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // Trace store depth and full count.
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] FIFO_FULL_COUNT = 4'h8;
    // Trigger modes.
    localparam logic [3:0] TRG_A_ONLY = 4'h0;
    localparam logic [3:0] TRG_A_OR_B = 4'h1;
    localparam logic [3:0] TRG_A_THEN_B = 4'h2;
    localparam logic [3:0] TRG_EVENT_B = 4'h3;
    localparam logic [3:0] TRG_A_THEN_EVENT_B = 4'h4;
    localparam logic [3:0] TRG_A_AND_B_DATA = 4'h5;
    localparam logic [3:0] TRG_A_AND_NOT_B_DATA = 4'h6;
    localparam logic [3:0] TRG_INSIDE = 4'h7;
    localparam logic [3:0] TRG_OUTSIDE = 4'h8;
    // Host AXI4-Lite register byte addresses, command fields and the status busy bit.
    localparam logic [3:0] HOST_CMD = 4'h0;
    localparam logic [3:0] HOST_STATUS = 4'h4;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_WRITE = 16;
    localparam int CMD_SERIAL = 17;
    localparam int HSTS_BUSY = 8;
endpackage

// file: logic/btb_if.sv
// Purpose: Register access link between the debug host and the monitor.
// Assumes: One clock; req held until a one-cycle ack.
// Notes: serial marks accesses issued through background debug commands.
`timescale 1ns/10ps
interface btb_if;
    logic req;
    logic wr;
    logic serial;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    modport device (input req, input wr, input serial, input addr, input wdata, output rdata, output ack);
    modport host (output req, output wr, output serial, output addr, output wdata, input rdata, input ack);
endinterface

// file: logic/btb_host.sv
// Purpose: Debug host end: turns AXI4-Lite commands into monitor register accesses.
// Assumes: Software orders FIFO reads high before low and primes profiling itself.
// Notes: One access under way at a time; commands while busy are dropped.
`timescale 1ns/10ps
module btb_host (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register link
    btb_if.host link,
    // AXI4-Lite write channels
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic aw_q;
    logic w_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic bvalid_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic req_q;
    logic wr_q;
    logic serial_q;
    logic [3:0] addr_q;
    logic [7:0] wbyte_q;
    logic [7:0] rbyte_q;
    logic go;

    assign s_axi_awready = !aw_q && !bvalid_q;
    assign s_axi_wready = !w_q && !bvalid_q;
    assign go = aw_q && w_q && !bvalid_q;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            bvalid_q <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (go)
            begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bvalid_q <= 1'b1;
            end
            else if (s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // A command starts one link access; the serial flag picks the background path.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            req_q <= 1'b0;
            wr_q <= 1'b0;
            serial_q <= 1'b0;
            addr_q <= 4'h0;
            wbyte_q <= 8'h00;
            rbyte_q <= 8'h00;
        end
        else if (req_q)
        begin
            if (link.ack)
            begin
                req_q <= 1'b0;
                rbyte_q <= link.rdata;
            end
        end
        else if (go && awaddr_q == btb_pkg::HOST_CMD && s_axi_wstrb != 4'h0)
        begin
            req_q <= 1'b1;
            wr_q <= wdata_q[btb_pkg::CMD_WRITE];
            serial_q <= wdata_q[btb_pkg::CMD_SERIAL];
            addr_q <= wdata_q[btb_pkg::CMD_ADDR_LSB +: 4];
            wbyte_q <= wdata_q[7:0];
        end
    end

    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            if (s_axi_araddr == btb_pkg::HOST_STATUS)
            begin
                rdata_q[7:0] <= rbyte_q;
                rdata_q[btb_pkg::HSTS_BUSY] <= req_q;
            end
        end
        else if (s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = 2'b00;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = 2'b00;
    assign link.req = req_q;
    assign link.wr = wr_q;
    assign link.serial = serial_q;
    assign link.addr = addr_q;
    assign link.wdata = wbyte_q;
endmodule

// file: verif/btb_props.sv
// Purpose: Concurrent checks on the register link between the debug host and the monitor.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Takes the link signals as plain inputs.
`timescale 1ns/10ps
module btb_props (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link signals
    input wire logic req,
    input wire logic wr,
    input wire logic serial,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    ack_follows_req_a:
        assert property (req && !ack |=> ack) else $error("No acknowledge after a request.");
    ack_one_cycle_a:
        assert property (ack |=> !ack) else $error("Acknowledge longer than one cycle.");
    ack_needs_req_a:
        assert property (ack |-> req) else $error("Acknowledge without a request.");
    reset_reg_zero_a:
        assert property (ack && !wr && addr == btb_pkg::OFS_FORCED_RESET |-> rdata == btb_pkg::RESET_BYTE)
        else $error("Forced reset register read not zero.");
    unmapped_zero_a:
        assert property (ack && !wr && addr > btb_pkg::OFS_STATUS |-> rdata == 8'h00)
        else $error("Unmapped offset read not zero.");
    count_bound_a:
        assert property (ack && !wr && addr == btb_pkg::OFS_STATUS |-> rdata[3:0] <= btb_pkg::FIFO_FULL_COUNT)
        else $error("Status count above eight.");
    write_keeps_data_a:
        assert property (ack && wr |-> $stable(rdata)) else $error("Read data moved on a write.");
    req_held_a:
        assert property (req && !ack |=> req && $stable(addr) && $stable(wr))
        else $error("Request changed before acknowledge.");

    cover property (ack && wr && serial && addr == btb_pkg::OFS_FORCED_RESET && wdata[0]);
    cover property (ack && !wr && addr == btb_pkg::OFS_FIFO_LOW);
    cover property (ack && wr && addr == btb_pkg::OFS_CONTROL);
endmodule

// file: verif/btb_tb_top.sv
// Purpose: Self-checking bench driving the host over AXI4-Lite and the monitor CPU side.
// Assumes: Host and monitor joined through btb_if.
// Notes: Expected values come from the register map and control bit meanings.
`timescale 1ns/10ps
module btb_tb_top;
    logic i_clk = 1'h0;
    logic i_rst = 1'h1;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, s;
    logic bus_valid = 1'h0, bus_read = 1'h0, fetch = 1'h0, exec = 1'h0, secure = 1'h0, begin_tr = 1'h0, qual = 1'h0;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_data = 8'h00;
    logic [3:0] trig_mode = 4'hF;
    logic force_rst, brk, brk_tag, armed;
    logic [3:0] fifo_cnt;
    logic [7:0] h, l;
    int errors = 0, n_checks = 0, cyc = 0, brk_cnt = 0, fr_cnt = 0, b0;

    btb_if link_if();
    btb_device btb_device_inst (.i_clk(i_clk), .i_rst(i_rst), .bus(link_if), .i_bus_valid(bus_valid),
        .i_bus_read(bus_read), .i_bus_addr(bus_addr), .i_bus_data(bus_data), .i_opcode_fetch(fetch),
        .i_opcode_exec(exec), .i_secure(secure), .i_trig_mode(trig_mode), .i_begin_trace(begin_tr),
        .i_trigger_qualify_select(qual), .o_force_reset(force_rst), .o_break_req(brk), .o_break_tag(brk_tag),
        .o_armed(armed), .o_fifo_count(fifo_cnt));
    btb_host btb_host_inst (.i_clk(i_clk), .i_rst(i_rst), .link(link_if), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    btb_props btb_props_inst (.i_clk(i_clk), .i_rst(i_rst), .req(link_if.req), .wr(link_if.wr),
        .serial(link_if.serial), .addr(link_if.addr), .wdata(link_if.wdata), .rdata(link_if.rdata),
        .ack(link_if.ack));

    always #12.5 i_clk = ~i_clk;

    task end_sim();
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge i_clk)
    begin
        cyc++;
        if (brk === 1'h1) brk_cnt++;
        if (force_rst === 1'h1) fr_cnt++;
        if (cyc == 30000)
        begin
            errors++;
            end_sim();
        end
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, b_ok;
        @(posedge i_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        b_ok = 1'h0;
        while (!b_ok)
        begin
            @(negedge i_clk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid && bready;
            @(posedge i_clk);
            if (aw_ok) awvalid <= 1'h0;
            if (w_ok) wvalid <= 1'h0;
        end
        bready <= 1'h0;
    endtask

    task axi_rd(input logic [3:0] a, output logic [31:0] d);
        logic ar_ok, r_ok;
        @(posedge i_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        r_ok = 1'h0;
        while (!r_ok)
        begin
            @(negedge i_clk);
            ar_ok = arvalid && arready;
            r_ok = rvalid && rready;
            d = rdata;
            @(posedge i_clk);
            if (ar_ok) arvalid <= 1'h0;
        end
        rready <= 1'h0;
    endtask

    task dev_poll(output logic [7:0] d);
        logic [31:0] st;
        st = 32'h0000_0100;
        while (st[8] !== 1'h0)
        begin
            axi_rd(btb_pkg::HOST_STATUS, st);
        end
        d = st[7:0];
    endtask

    task dev_wr(input logic [3:0] off, input logic [7:0] d, input logic ser);
        logic [7:0] t;
        axi_wr(btb_pkg::HOST_CMD, {14'h0000, ser, 1'h1, 4'h0, off, d});
        dev_poll(t);
    endtask

    task dev_rd(input logic [3:0] off, output logic [7:0] d);
        axi_wr(btb_pkg::HOST_CMD, {14'h0000, 1'h0, 1'h0, 4'h0, off, 8'h00});
        dev_poll(d);
    endtask

    task cpu_cycle(input logic rd, input logic [15:0] a, input logic [7:0] d, input logic [1:0] k);
        @(posedge i_clk);
        bus_valid <= 1'h1;
        bus_read <= rd;
        bus_addr <= a;
        bus_data <= d;
        fetch <= k[0];
        exec <= k[1];
        @(posedge i_clk);
        bus_valid <= 1'h0;
        fetch <= 1'h0;
        exec <= 1'h0;
    endtask

    task trig(input logic [7:0] ctl, input logic rd, input logic [15:0] a, input logic [15:0] nb, input logic arm);
        b0 = brk_cnt;
        dev_wr(btb_pkg::OFS_CONTROL, ctl, 1'h0);
        cpu_cycle(rd, a, 8'h00, 2'h2);
        repeat (4) @(posedge i_clk);
        chk(16'(brk_cnt - b0), nb);
        chk({15'h0000, armed}, {15'h0000, arm});
        chk({15'h0000, brk_tag}, {15'h0000, ctl[5]});
        dev_wr(btb_pkg::OFS_CONTROL, 8'h80, 1'h0);
    endtask

    initial
    begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'h0;
        for (int k = 0; k < 10; k++)
        begin
            dev_rd(4'(k), l);
            chk({8'h00, l}, 16'h0000);
        end
        axi_rd(4'h8, s);
        chk(s[15:0], 16'h0000);
        dev_wr(btb_pkg::OFS_FIFO_HIGH, 8'hAA, 1'h0);
        dev_wr(btb_pkg::OFS_FIFO_LOW, 8'hAA, 1'h0);
        dev_wr(btb_pkg::OFS_STATUS, 8'hFF, 1'h0);
        dev_rd(btb_pkg::OFS_FIFO_HIGH, h);
        chk({8'h00, h}, 16'h0000);
        dev_rd(btb_pkg::OFS_STATUS, l);
        chk({8'h00, l}, 16'h0000);
        b0 = fr_cnt;
        dev_wr(btb_pkg::OFS_FORCED_RESET, 8'h01, 1'h0);
        chk(16'(fr_cnt - b0), 16'h0000);
        dev_wr(btb_pkg::OFS_FORCED_RESET, 8'h01, 1'h1);
        chk(16'(fr_cnt - b0), 16'h0001);
        dev_rd(btb_pkg::OFS_FORCED_RESET, l);
        chk({8'h00, l}, 16'h0000);
        for (int k = 1; k < 5; k++) dev_wr(4'(k), 8'(8'h12 + 8'h22 * (k - 1)), 1'h0);
        for (int k = 1; k < 5; k++)
        begin
            dev_rd(4'(k), l);
            chk({8'h00, l}, 16'(8'h12 + 8'h22 * (k - 1)));
        end
        secure <= 1'h1;
        dev_wr(btb_pkg::OFS_CONTROL, 8'h80, 1'h0);
        dev_rd(btb_pkg::OFS_CONTROL, l);
        chk({8'h00, l}, 16'h0000);
        secure <= 1'h0;
        dev_wr(btb_pkg::OFS_CONTROL, 8'hC0, 1'h0);
        dev_wr(btb_pkg::OFS_CMP_A_HIGH, 8'hFF, 1'h0);
        dev_rd(btb_pkg::OFS_CONTROL, l);
        chk({8'h00, l}, 16'h00C0);
        dev_rd(btb_pkg::OFS_CMP_A_HIGH, l);
        chk({8'h00, l}, 16'h0012);
        dev_wr(btb_pkg::OFS_CONTROL, 8'h80, 1'h0);
        chk({15'h0000, armed}, 16'h0000);
        trig_mode <= btb_pkg::TRG_A_ONLY;
        trig(8'hDC, 1'h0, 16'h1234, 16'h0000, 1'h1);
        trig(8'hDC, 1'h1, 16'h1234, 16'h0001, 1'h0);
        trig(8'hD0, 1'h0, 16'h1235, 16'h0000, 1'h1);
        trig(8'hC0, 1'h0, 16'h1234, 16'h0000, 1'h0);
        trig(8'hF0, 1'h0, 16'h1234, 16'h0001, 1'h0);
        qual <= 1'h1;
        trig(8'hD0, 1'h0, 16'h1234, 16'h0001, 1'h0);
        qual <= 1'h0;
        trig_mode <= btb_pkg::TRG_A_OR_B;
        trig(8'hD1, 1'h1, 16'h5678, 16'h0000, 1'h1);
        trig(8'hD1, 1'h0, 16'h5678, 16'h0001, 1'h0);
        trig_mode <= btb_pkg::TRG_EVENT_B;
        b0 = brk_cnt;
        dev_wr(btb_pkg::OFS_CONTROL, 8'hD0, 1'h0);
        for (int k = 0; k < 7; k++) cpu_cycle(1'h0, 16'h5678, 8'(8'h30 + k), 2'h0);
        chk({15'h0000, armed}, 16'h0001);
        dev_rd(btb_pkg::OFS_FIFO_LOW, h);
        dev_rd(btb_pkg::OFS_FIFO_LOW, l);
        chk({8'h00, h}, {8'h00, l});
        cpu_cycle(1'h0, 16'h5678, 8'h37, 2'h0);
        repeat (4) @(posedge i_clk);
        chk({15'h0000, armed}, 16'h0000);
        chk(16'(brk_cnt - b0), 16'h0001);
        chk({12'h000, fifo_cnt}, 16'h0008);
        dev_rd(btb_pkg::OFS_STATUS, l);
        chk({11'h000, l[5], l[3:0]}, 16'h0008);
        trig_mode <= 4'hF;
        for (int k = 0; k < 12; k++)
        begin
            cpu_cycle(1'h1, 16'(16'h4410 + k), 8'h00, 2'h1);
            dev_rd(btb_pkg::OFS_FIFO_HIGH, h);
            dev_rd(btb_pkg::OFS_FIFO_LOW, l);
            chk({h, l}, k < 8 ? 16'(16'h0030 + k) : 16'(16'h4408 + k));
        end
        dev_wr(btb_pkg::OFS_CONTROL, 8'hC0, 1'h0);
        i_rst <= 1'h1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'h0;
        dev_rd(btb_pkg::OFS_CONTROL, l);
        chk({7'h00, armed, l}, 16'h0000);
        end_sim();
    end
endmodule
